// ### otrb_pkg.sv
// Constants, types and shared functions of the offset trim register bank.
package otrb_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int OTRB_DATA_W   = 8;
   localparam int OTRB_ADDR_W   = 8;
   localparam int OTRB_LEVEL_W  = 9;
   localparam int OTRB_MON_W    = 9;
   localparam int OTRB_NUM_REGS = 7;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [7:0] OTRB_OFS_LEFT_PAIR   = 8'h46;
   localparam logic [7:0] OTRB_OFS_LEFT_CM     = 8'h47;
   localparam logic [7:0] OTRB_OFS_RIGHT_PAIR  = 8'h48;
   localparam logic [7:0] OTRB_OFS_RIGHT_CM    = 8'h49;
   localparam logic [7:0] OTRB_OFS_SPARE_A     = 8'h4A;
   localparam logic [7:0] OTRB_OFS_SPARE_B     = 8'h4B;
   localparam logic [7:0] OTRB_OFS_MONITOR_TOP = 8'h4C;

   // ***************************************************************
   // Register indices, offset table and stored-bit masks
   // ***************************************************************
   localparam int OTRB_IDX_LEFT_PAIR   = 0;
   localparam int OTRB_IDX_LEFT_CM     = 1;
   localparam int OTRB_IDX_RIGHT_PAIR  = 2;
   localparam int OTRB_IDX_RIGHT_CM    = 3;
   localparam int OTRB_IDX_SPARE_A     = 4;
   localparam int OTRB_IDX_SPARE_B     = 5;
   localparam int OTRB_IDX_MONITOR_TOP = 6;

   localparam logic [7:0] OTRB_OFFSET_TABLE [0:OTRB_NUM_REGS-1] = '{
      OTRB_OFS_LEFT_PAIR, OTRB_OFS_LEFT_CM, OTRB_OFS_RIGHT_PAIR, OTRB_OFS_RIGHT_CM,
      OTRB_OFS_SPARE_A, OTRB_OFS_SPARE_B, OTRB_OFS_MONITOR_TOP};

   localparam logic [7:0] OTRB_MASK_TABLE [0:OTRB_NUM_REGS-1] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFE};

   // ***************************************************************
   // Values after reset
   // ***************************************************************
   localparam logic [7:0] OTRB_RESET_BYTE  = 8'h00;
   localparam logic [8:0] OTRB_RESET_LEVEL = 9'h000;
   localparam logic [7:0] OTRB_READ_ZERO   = 8'h00;
   localparam int         OTRB_MON_SIGN    = 8;

   typedef logic signed [OTRB_LEVEL_W-1:0] otrb_level_type;

   // ***************************************************************
   // Shared functions
   // ***************************************************************
   // Turns a trim code into a signed count of 0.25 mV steps with inverted sign.
   function automatic otrb_level_type otrb_trim_level(input logic [7:0] code, input logic is_cm);
      logic [8:0] ext;
      ext = is_cm ? {code[7], code} : {code[6], code[6], code[6:0]};
      return otrb_level_type'(9'h000 - ext);
   endfunction

   // Tells whether an address selects a given register.
   function automatic logic otrb_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

endpackage

// ### otrb_byte_reg.sv
// One byte of software storage with write enable and bit mask.
module otrb_byte_reg
   import otrb_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hFF
)
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   output      logic [7:0] value
);

   logic [7:0] next_value;

   always_comb
   begin
      next_value = value;
      if (wr_en)
      begin
         next_value = wdata & MASK;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         value <= OTRB_RESET_BYTE;
      end
      else
      begin
         value <= next_value;
      end
   end

endmodule // otrb_byte_reg

// ### otrb_trim_decode.sv
// Registered conversion of a trim code into a signed compensator level.
module otrb_trim_decode
   import otrb_pkg::*;
#(
   parameter bit IS_CM = 1'b0
)
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic [7:0]              code,
   output      logic [OTRB_LEVEL_W-1:0] level
);

   logic [OTRB_LEVEL_W-1:0] next_level;

   always_comb
   begin
      next_level = otrb_trim_level(code, IS_CM);
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         level <= OTRB_RESET_LEVEL;
      end
      else
      begin
         level <= next_level;
      end
   end

endmodule // otrb_trim_decode

// ### otrb_bank.sv
// Top of the offset trim register bank: register port, storage, read-back and levels.
module otrb_bank
   import otrb_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire logic [OTRB_ADDR_W-1:0]  reg_addr,
   input  wire logic [OTRB_DATA_W-1:0]  reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output      logic [OTRB_DATA_W-1:0]  reg_rdata,
   output      logic                    reg_rvalid,
   input  wire logic [OTRB_MON_W-1:0]   left_pair_monitor,
   output      logic [OTRB_LEVEL_W-1:0] left_pair_offset,
   output      logic [OTRB_LEVEL_W-1:0] left_common_mode_offset,
   output      logic [OTRB_LEVEL_W-1:0] right_pair_offset,
   output      logic [OTRB_LEVEL_W-1:0] right_common_mode_offset
);

   // ***************************************************************
   // Register storage
   // ***************************************************************
   logic [7:0] reg_value [0:OTRB_NUM_REGS-1];
   logic [7:0] read_mux;
   logic [7:0] next_rdata;
   logic       next_rvalid;
   logic       left_pair_monitor_top_bit;

   genvar gi;
   generate
      for (gi = 0; gi < OTRB_NUM_REGS; gi++)
      begin : g_reg
         otrb_byte_reg #(
            .MASK (OTRB_MASK_TABLE[gi])
         ) u_reg (
            .clock (clock),
            .rst   (rst),
            .wr_en (reg_wr && otrb_hit(reg_addr, OTRB_OFFSET_TABLE[gi])),
            .wdata (reg_wdata),
            .value (reg_value[gi])
         );
      end
   endgenerate

   // ***************************************************************
   // Compensator levels
   // ***************************************************************
   // Left pair decode.
   otrb_trim_decode #(
      .IS_CM (1'b0)
   ) u_left_pair (
      .clock (clock),
      .rst   (rst),
      .code  (reg_value[OTRB_IDX_LEFT_PAIR]),
      .level (left_pair_offset)
   );

   otrb_trim_decode #(
      .IS_CM (1'b1)
   ) u_left_cm (
      .clock (clock),
      .rst   (rst),
      .code  (reg_value[OTRB_IDX_LEFT_CM]),
      .level (left_common_mode_offset)
   );

   otrb_trim_decode #(
      .IS_CM (1'b0)
   ) u_right_pair (
      .clock (clock),
      .rst   (rst),
      .code  (reg_value[OTRB_IDX_RIGHT_PAIR]),
      .level (right_pair_offset)
   );

   otrb_trim_decode #(
      .IS_CM (1'b1)
   ) u_right_cm (
      .clock (clock),
      .rst   (rst),
      .code  (reg_value[OTRB_IDX_RIGHT_CM]),
      .level (right_common_mode_offset)
   );

   // ***************************************************************
   // Read-back
   // ***************************************************************
   // Monitor sign bit, uninverted.
   assign left_pair_monitor_top_bit = left_pair_monitor[OTRB_MON_SIGN];

   always_comb
   begin
      read_mux = OTRB_READ_ZERO;
      for (int i = 0; i < OTRB_NUM_REGS; i++)
      begin
         if (otrb_hit(reg_addr, OTRB_OFFSET_TABLE[i]))
         begin
            read_mux = reg_value[i];
         end
      end
      if (otrb_hit(reg_addr, OTRB_OFS_MONITOR_TOP))
      begin
         read_mux = {reg_value[OTRB_IDX_MONITOR_TOP][7:1], left_pair_monitor_top_bit};
      end
      next_rvalid = reg_rd;
      next_rdata  = reg_rd ? read_mux : OTRB_READ_ZERO;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         reg_rdata  <= OTRB_READ_ZERO;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rdata  <= next_rdata;
         reg_rvalid <= next_rvalid;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_wr(logic [7:0] ofs);
      reg_wr && reg_addr == ofs;
   endsequence

   sequence s_rd(logic [7:0] ofs);
      reg_rd && !reg_wr && reg_addr == ofs;
   endsequence

   property p_left_pair_store;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_LEFT_PAIR) ##1 s_rd(OTRB_OFS_LEFT_PAIR) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_left_pair_store: assert property (p_left_pair_store) else $error("left pair trim read-back wrong");

   property p_left_pair_level;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_LEFT_PAIR) |=> ##1 left_pair_offset == otrb_trim_level($past(reg_wdata, 2), 1'b0);
   endproperty
   a_left_pair_level: assert property (p_left_pair_level) else $error("left pair level wrong");

   property p_left_cm_store;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_LEFT_CM) |=> reg_value[OTRB_IDX_LEFT_CM] == $past(reg_wdata);
   endproperty
   a_left_cm_store: assert property (p_left_cm_store) else $error("left loop trim not stored");

   property p_left_cm_level;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_LEFT_CM) |=> ##1 left_common_mode_offset == otrb_trim_level($past(reg_wdata, 2), 1'b1);
   endproperty
   a_left_cm_level: assert property (p_left_cm_level) else $error("left loop level wrong");

   property p_right_pair_level;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_RIGHT_PAIR) |=> ##1 right_pair_offset == otrb_trim_level($past(reg_wdata, 2), 1'b0);
   endproperty
   a_right_pair_level: assert property (p_right_pair_level) else $error("right pair level wrong");

   property p_right_cm_level;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_RIGHT_CM) |=> ##1 right_common_mode_offset == otrb_trim_level($past(reg_wdata, 2), 1'b1);
   endproperty
   a_right_cm_level: assert property (p_right_cm_level) else $error("right loop level wrong");

   property p_monitor_bit;
      @(posedge clock) disable iff (rst)
      s_rd(OTRB_OFS_MONITOR_TOP) |=> reg_rvalid && reg_rdata[0] == $past(left_pair_monitor[OTRB_MON_SIGN]);
   endproperty
   a_monitor_bit: assert property (p_monitor_bit) else $error("monitor top bit wrong");

   property p_monitor_sign;
      @(posedge clock) disable iff (rst)
      s_rd(OTRB_OFS_MONITOR_TOP) |=> reg_rdata[0] == ($past($signed(left_pair_monitor)) < 0);
   endproperty
   a_monitor_sign: assert property (p_monitor_sign) else $error("monitor sign inverted");

   property p_spare_inert;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_SPARE_A) ##1 s_rd(OTRB_OFS_SPARE_A) |=> reg_rdata == $past(reg_wdata, 2) && $stable(left_pair_offset);
   endproperty
   a_spare_inert: assert property (p_spare_inert) else $error("spare byte misbehaves");

   property p_read_answer;
      @(posedge clock) disable iff (rst)
      reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd));
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer timing wrong");

   sequence s_quiet(logic [7:0] ofs);
      !(reg_wr && reg_addr == ofs);
   endsequence

   property p_left_pair_hold;
      @(posedge clock) disable iff (rst)
      s_quiet(OTRB_OFS_LEFT_PAIR) |=> $stable(reg_value[OTRB_IDX_LEFT_PAIR]);
   endproperty
   a_left_pair_hold: assert property (p_left_pair_hold) else $error("left pair trim changed");

   property p_left_pair_quiet;
      @(posedge clock) disable iff (rst)
      s_quiet(OTRB_OFS_LEFT_PAIR) |=> ##1 $stable(left_pair_offset);
   endproperty
   a_left_pair_quiet: assert property (p_left_pair_quiet) else $error("left pair level moved");

   property p_left_cm_readback;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_LEFT_CM) ##1 s_rd(OTRB_OFS_LEFT_CM) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_left_cm_readback: assert property (p_left_cm_readback) else $error("left loop read-back wrong");

   property p_left_cm_quiet;
      @(posedge clock) disable iff (rst)
      s_quiet(OTRB_OFS_LEFT_CM) |=> ##1 $stable(left_common_mode_offset);
   endproperty
   a_left_cm_quiet: assert property (p_left_cm_quiet) else $error("left loop level moved");

   property p_right_pair_store;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_RIGHT_PAIR) |=> reg_value[OTRB_IDX_RIGHT_PAIR] == $past(reg_wdata);
   endproperty
   a_right_pair_store: assert property (p_right_pair_store) else $error("right pair trim not stored");

   property p_right_pair_readback;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_RIGHT_PAIR) ##1 s_rd(OTRB_OFS_RIGHT_PAIR) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_right_pair_readback: assert property (p_right_pair_readback) else $error("right pair read-back wrong");

   property p_right_cm_store;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_RIGHT_CM) |=> reg_value[OTRB_IDX_RIGHT_CM] == $past(reg_wdata);
   endproperty
   a_right_cm_store: assert property (p_right_cm_store) else $error("right loop trim not stored");

   property p_right_cm_readback;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_RIGHT_CM) ##1 s_rd(OTRB_OFS_RIGHT_CM) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_right_cm_readback: assert property (p_right_cm_readback) else $error("right loop read-back wrong");

   property p_monitor_ro;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_MONITOR_TOP) |=> reg_value[OTRB_IDX_MONITOR_TOP] == {$past(reg_wdata[7:1]), 1'b0};
   endproperty
   a_monitor_ro: assert property (p_monitor_ro) else $error("monitor bit was written");

   property p_monitor_readback;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_MONITOR_TOP) ##1 s_rd(OTRB_OFS_MONITOR_TOP)
         |=> reg_rdata == {$past(reg_wdata[7:1], 2), $past(left_pair_monitor[OTRB_MON_SIGN])};
   endproperty
   a_monitor_readback: assert property (p_monitor_readback) else $error("monitor byte read-back wrong");

   property p_spare_b_inert;
      @(posedge clock) disable iff (rst)
      s_wr(OTRB_OFS_SPARE_B) ##1 s_rd(OTRB_OFS_SPARE_B)
         |=> reg_rdata == $past(reg_wdata, 2) && $stable(right_common_mode_offset);
   endproperty
   a_spare_b_inert: assert property (p_spare_b_inert) else $error("second spare byte misbehaves");

   property p_unmapped_read;
      @(posedge clock) disable iff (rst)
      reg_rd && (reg_addr < OTRB_OFS_LEFT_PAIR || reg_addr > OTRB_OFS_MONITOR_TOP)
         |=> reg_rvalid && reg_rdata == OTRB_READ_ZERO;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_reset_spares;
      @(posedge clock)
      rst |=> reg_value[OTRB_IDX_SPARE_A] == OTRB_RESET_BYTE && reg_value[OTRB_IDX_SPARE_B] == OTRB_RESET_BYTE
         && reg_value[OTRB_IDX_MONITOR_TOP] == OTRB_RESET_BYTE;
   endproperty
   a_reset_spares: assert property (p_reset_spares) else $error("spare bytes not cleared by reset");

   property p_reset_trims;
      @(posedge clock)
      rst |=> reg_value[OTRB_IDX_LEFT_PAIR] == OTRB_RESET_BYTE && reg_value[OTRB_IDX_LEFT_CM] == OTRB_RESET_BYTE
         && reg_value[OTRB_IDX_RIGHT_PAIR] == OTRB_RESET_BYTE && reg_value[OTRB_IDX_RIGHT_CM] == OTRB_RESET_BYTE;
   endproperty
   a_reset_trims: assert property (p_reset_trims) else $error("trim bytes not cleared by reset");

   property p_reset_levels;
      @(posedge clock)
      rst |=> left_pair_offset == OTRB_RESET_LEVEL && left_common_mode_offset == OTRB_RESET_LEVEL
         && right_pair_offset == OTRB_RESET_LEVEL && right_common_mode_offset == OTRB_RESET_LEVEL;
   endproperty
   a_reset_levels: assert property (p_reset_levels) else $error("levels not cleared by reset");

   property p_idle_read;
      @(posedge clock) disable iff (rst)
      !reg_rd |=> !reg_rvalid && reg_rdata == OTRB_READ_ZERO;
   endproperty
   a_idle_read: assert property (p_idle_read) else $error("read answer without read");

   property p_read_old;
      @(posedge clock) disable iff (rst)
      reg_rd && reg_wr && reg_addr == OTRB_OFS_LEFT_PAIR
         |=> reg_rdata == $past(reg_value[OTRB_IDX_LEFT_PAIR]);
   endproperty
   a_read_old: assert property (p_read_old) else $error("read with write not old value");

endmodule // otrb_bank

// ### test_otrb_bank.sv
// Self-checking testbench of the offset trim register bank.
module test_otrb_bank
   import otrb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************************
   // Signals and scoreboard
   // ***************************************************************
   localparam logic [7:0] CODES [0:5] = '{8'h3F, 8'h40, 8'h7F, 8'h80, 8'hC0, 8'h00};
   logic       clock;
   logic       rst;
   logic       reg_wr;
   logic       reg_rd;
   logic       reg_rvalid;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [8:0] left_pair_monitor;
   logic [8:0] lp_off;
   logic [8:0] lc_off;
   logic [8:0] rp_off;
   logic [8:0] rc_off;
   logic [7:0] shadow [0:6];
   logic [7:0] exp_q [$];
   int         num_errors = 0;
   int         checked    = 0;
   int         seed       = 32'hc268;

   otrb_bank u_dut (
      .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .left_pair_monitor(left_pair_monitor), .left_pair_offset(lp_off),
      .left_common_mode_offset(lc_off), .right_pair_offset(rp_off), .right_common_mode_offset(rc_off));

   // ***************************************************************
   // Tasks and models
   // ***************************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [7:0] read_model(input logic [7:0] a, input logic [8:0] mon);
      if (a >= 8'h46 && a <= 8'h4B)
         return shadow[a - 8'h46];
      if (a == 8'h4C)
         return {shadow[6][7:1], mon[8]};
      return 8'h00;
   endfunction

   function automatic logic [8:0] level(input logic [7:0] c, input bit cm);
      return 9'h000 - (cm ? {c[7], c} : {{2{c[6]}}, c[6:0]});
   endfunction

   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                     input logic [8:0] m);
      @(posedge clock);
      reg_wr            <= w;
      reg_rd            <= r;
      reg_addr          <= a;
      reg_wdata         <= d;
      left_pair_monitor <= m;
      if (r)
         exp_q.push_back(read_model(a, m));
      if (w && a >= 8'h46 && a <= 8'h4C)
         shadow[a - 8'h46] = (a == 8'h4C) ? {d[7:1], 1'b0} : d;
   endtask

   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge clock);
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
      end
   endtask

   task automatic check_levels;
      idle(3);
      @(negedge clock);
      check("left_pair_offset", lp_off, level(shadow[0], 0));
      check("left_cm_offset", lc_off, level(shadow[1], 1));
      check("right_pair_offset", rp_off, level(shadow[2], 0));
      check("right_cm_offset", rc_off, level(shadow[3], 1));
   endtask

   task automatic reset_run(input int n);
      @(posedge clock);
      rst    <= 1'b1;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clock);
      rst <= 1'b0;
      foreach (shadow[i]) shadow[i] = 8'h00;
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ***************************************************************
   // Clock, result watcher and watchdog
   // ***************************************************************
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   initial
   forever
   begin
      @(negedge clock);
      if (reg_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("unexpected rvalid", 16'h1, 16'h0);
         else
            check("reg_rdata", reg_rdata, exp_q.pop_front());
      end
      else if (rst === 1'b0)
         check("idle rdata", reg_rdata, 8'h00);
   end

   initial
   begin
      repeat (3000) @(posedge clock);
      num_errors++;
      complete_run;
   end

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial
   begin
      logic [31:0] r;
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      left_pair_monitor = 9'h000;
      reset_run(12);
      for (int a = 8'h44; a <= 8'h4E; a++) op(0, 1, a[7:0], 8'h00, 9'h000);
      check_levels;
      $display("test reset values done");
      foreach (CODES[i])
      begin
         for (int a = 0; a < 4; a++) op(1, 0, 8'h46 + a[7:0], CODES[(i + a) % 6], 9'h000);
         check_levels;
      end
      $display("test trim levels done");
      op(1, 0, 8'h4C, 8'hFF, 9'h000);
      op(0, 1, 8'h4C, 8'h00, 9'h100);
      op(0, 1, 8'h4C, 8'h00, 9'h0FF);
      // random traffic over the bank and its neighbours
      repeat (200)
      begin
         r = $random(seed);
         op(r[0], r[1], 8'h44 + {4'h0, r[5:2]} % 8'h0B, r[15:8], r[24:16]);
      end
      for (int a = 8'h44; a <= 8'h4E; a++) op(0, 1, a[7:0], 8'h00, 9'h100);
      check_levels;
      $display("test random traffic done");
      reset_run(2);
      for (int a = 8'h46; a <= 8'h4C; a++) op(0, 1, a[7:0], 8'h00, 9'h000);
      check_levels;
      check("pending reads", 16'(exp_q.size()), 16'h0);
      $display("test second reset done");
      complete_run;
   end

endmodule // test_otrb_bank
